// ---- inc/vpg_pkg.sv ----
// Package of constants and carrier types for the vertical pattern generator.
// Functional notes
// [RL1] Four patterns, each with its own 9-bit repeat period of 0 to 511 counts.
// [RL2] Per pattern and phase, a start level bit: 0 is low, 1 is high.
// [RL3] Per pattern and phase, a 9-bit first edge position compared with the counter.
// [RL4] Per pattern and phase, a 9-bit second edge position toggling the output again.
// [RL5] Five regions each have a 3-bit slot pointer; values 0 to 3 pick that slot.
// [RL6] Slot pointer 4 uses slot 0 on even lines and slot 1 on odd lines.
// [RL7] Slot pointer 5 uses slot 2 on even lines and slot 3 on odd lines.
// [RL8] Software never programs a slot pointer to 6 or 7; behaviour is undefined.
// [RL9] Four 2-bit slot choices each name pattern 0 to 3.
// [RL10] Each pattern has a 3-bit repeat count giving periods output per line.
// [RL11] Four 8-bit region boundaries give the line where the next region starts.
// [RL12] Pointers, choices, counts and boundaries exist in sets A and B; active set rules.
// [RL13] Count 1 gives one period; count 0 holds start levels for the whole line.
// [RL14] The first region always starts at line 0, at the field sync falling edge.
// [RL15] Period and edges count pixel clocks within the current line.
// [RL16] Counter restarts each line; repeats run back to back, then levels hold.
// [RL17] Software programs region boundaries in ascending line order.
package vpg_pkg;

	// ----------------------------------------------------------------------
	// Sizes and encodings
	// ----------------------------------------------------------------------
	localparam int unsigned VPG_NUM_PAT    = 4;
	localparam int unsigned VPG_NUM_PHASE  = 4;
	localparam int unsigned VPG_NUM_REGION = 5;
	localparam int unsigned VPG_NUM_SLOT   = 4;
	localparam int unsigned VPG_NUM_BOUND  = 4;
	localparam int unsigned VPG_POS_W      = 9;
	localparam int unsigned VPG_LINE_W     = 8;
	localparam int unsigned VPG_PTR_W      = 3;
	localparam int unsigned VPG_REP_W      = 3;
	localparam int unsigned VPG_SEL_W      = 2;
	localparam int unsigned VPG_REGION_W   = 3;

	localparam logic [VPG_PTR_W-1:0] VPG_PTR_ALT01 = 3'h4;
	localparam logic [VPG_PTR_W-1:0] VPG_PTR_ALT23 = 3'h5;

	// ----------------------------------------------------------------------
	// Values after reset, and the line number limit
	// ----------------------------------------------------------------------
	localparam logic [VPG_LINE_W-1:0]    VPG_LINE_RST   = 8'h00;
	localparam logic [VPG_LINE_W-1:0]    VPG_LINE_MAX   = 8'hff;
	localparam logic [VPG_POS_W-1:0]     VPG_CNT_RST    = 9'h000;
	localparam logic [VPG_REP_W-1:0]     VPG_REP_RST    = 3'h0;
	localparam logic [VPG_SEL_W-1:0]     VPG_SEL_RST    = 2'h0;
	localparam logic [VPG_REGION_W-1:0]  VPG_REGION_RST = 3'h0;
	localparam logic [VPG_NUM_PHASE-1:0] VPG_PHASE_RST  = 4'h0;

	// ----------------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [VPG_POS_W-1:0]                     period;
		logic [VPG_NUM_PHASE-1:0]                 start_level;
		logic [VPG_NUM_PHASE-1:0][VPG_POS_W-1:0] edge_first;
		logic [VPG_NUM_PHASE-1:0][VPG_POS_W-1:0] edge_second;
	} vpg_pat_cfg_t;

	typedef struct packed {
		logic [VPG_NUM_REGION-1:0][VPG_PTR_W-1:0]  slot_pointer;
		logic [VPG_NUM_SLOT-1:0][VPG_SEL_W-1:0]    pattern_choice;
		logic [VPG_NUM_PAT-1:0][VPG_REP_W-1:0]     repeat_count;
		logic [VPG_NUM_BOUND-1:0][VPG_LINE_W-1:0]  boundary_line;
	} vpg_mode_cfg_t;

endpackage

// ---- core/vpg_core.sv ----
// Vertical transfer clock pattern generator for a four-phase CCD.
`timescale 1ns/1ps
`default_nettype none

module vpg_core
	import vpg_pkg::*;
(
	// Clock and reset.
	input  wire logic                               i_clk_sys,
	input  wire logic                               i_arst_n,
	// Syncs; the falling edge marks a start.
	input  wire logic                               i_line_sync,
	input  wire logic                               i_field_sync,
	// Pattern definitions and the two mode sets.
	input  wire vpg_pat_cfg_t [VPG_NUM_PAT-1:0]     i_pat_cfg,
	input  wire vpg_mode_cfg_t                      i_mode_a,
	input  wire vpg_mode_cfg_t                      i_mode_b,
	input  wire logic                               i_mode_b_sel,
	// Phase outputs and state.
	output logic [VPG_NUM_PHASE-1:0]                o_vphase,
	output logic [VPG_LINE_W-1:0]                   o_line_num,
	output logic [VPG_REGION_W-1:0]                 o_region,
	output logic [VPG_SEL_W-1:0]                    o_pattern,
	output logic                                    o_active
);

	// ----------------------------------------------------------------------
	// Decoding functions
	// ----------------------------------------------------------------------
	// Region is the count of boundaries already passed; ascending order assumed.
	function automatic logic [VPG_REGION_W-1:0] vpg_region(
		input logic [VPG_LINE_W-1:0]                   line,
		input logic [VPG_NUM_BOUND-1:0][VPG_LINE_W-1:0] bound
	);
		logic [VPG_REGION_W-1:0] r;
		r = VPG_REGION_RST;
		for (int i = 0; i < VPG_NUM_BOUND; i++) begin
			if (line >= bound[i]) begin
				r = VPG_REGION_W'(i + 1);
			end
		end
		return r;
	endfunction

	// Pointer to slot; codes 6 and 7 are never programmed and fall to slot 0.
	function automatic logic [VPG_SEL_W-1:0] vpg_slot(
		input logic [VPG_PTR_W-1:0] ptr,
		input logic                 odd
	);
		logic [VPG_SEL_W-1:0] s;
		s = VPG_SEL_RST;
		if (ptr < VPG_PTR_ALT01) begin
			s = ptr[VPG_SEL_W-1:0];
		end else if (ptr == VPG_PTR_ALT01) begin
			s = {1'b0, odd};
		end else if (ptr == VPG_PTR_ALT23) begin
			s = {1'b1, odd};
		end
		return s;
	endfunction

	// ----------------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------------
	// Registered state of the line in progress.
	logic                          line_prev_reg;
	logic                          field_prev_reg;
	logic                          field_pend_reg;
	logic [VPG_LINE_W-1:0]         line_reg;
	logic [VPG_REGION_W-1:0]       region_reg;
	logic [VPG_SEL_W-1:0]          slot_reg;
	logic [VPG_SEL_W-1:0]          pat_reg;
	logic [VPG_REP_W-1:0]          reps_left_reg;
	logic [VPG_POS_W-1:0]          vcnt_reg;
	logic [VPG_NUM_PHASE-1:0]      phase_reg;
	// Decode of the line that is about to start.
	logic                          line_start;
	logic                          field_start;
	logic [VPG_LINE_W-1:0]         line_next;
	logic [VPG_REGION_W-1:0]       region_next;
	logic [VPG_PTR_W-1:0]          ptr_next;
	logic [VPG_SEL_W-1:0]          slot_next;
	logic [VPG_SEL_W-1:0]          pat_next;
	logic [VPG_REP_W-1:0]          rep_next;
	logic                          active;
	logic                          wrap;
	vpg_mode_cfg_t                 mode;
	vpg_pat_cfg_t                  cur_cfg;

	// ----------------------------------------------------------------------
	// Sync edges and selection for the coming line
	// ----------------------------------------------------------------------
	// The live set is used, so a set change takes hold at the next line start.
	// The line number sticks at 255 instead of wrapping back into region 0.
	assign mode        = i_mode_b_sel ? i_mode_b : i_mode_a;      // [RL12]
	assign line_start  = line_prev_reg & ~i_line_sync;
	assign field_start = field_prev_reg & ~i_field_sync;
	assign line_next   = (field_start | field_pend_reg) ? VPG_LINE_RST :    // [RL14]
	                     (line_reg == VPG_LINE_MAX) ? line_reg : line_reg + 8'h01;
	assign region_next = vpg_region(line_next, mode.boundary_line);      // [RL11]
	assign ptr_next    = mode.slot_pointer[region_next];                 // [RL5]
	assign slot_next   = vpg_slot(ptr_next, line_next[0]);              // [RL6] [RL7]
	assign pat_next    = mode.pattern_choice[slot_next];                 // [RL9]
	assign rep_next    = mode.repeat_count[pat_next];                    // [RL10]

	// Sync history; idle level is high so no start is seen out of reset.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			line_prev_reg  <= 1'b1;
			field_prev_reg <= 1'b1;
		end else begin
			line_prev_reg  <= i_line_sync;
			field_prev_reg <= i_field_sync;
		end
	end

	// Line number; a field start mid-line makes the next line number 0.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			field_pend_reg <= 1'b0;
			line_reg       <= VPG_LINE_RST;
		end else begin
			if (line_start) begin
				line_reg       <= line_next;
				field_pend_reg <= 1'b0;
			end else if (field_start) begin
				field_pend_reg <= 1'b1;
			end
		end
	end

	// Pattern selection is frozen for the whole line at its start.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			region_reg <= VPG_REGION_RST;
			slot_reg   <= VPG_SEL_RST;
			pat_reg    <= VPG_SEL_RST;
		end else if (line_start) begin
			region_reg <= region_next;
			slot_reg   <= slot_next;
			pat_reg    <= pat_next;
		end
	end

	// ----------------------------------------------------------------------
	// Pixel counter and repetitions
	// ----------------------------------------------------------------------
	// Period and edges are read live, so a rewrite mid-line acts at once; this
	// is cheaper than keeping a second copy of every pattern.
	assign cur_cfg = i_pat_cfg[pat_reg];                               // [RL1]
	assign active  = (reps_left_reg != VPG_REP_RST);
	// A period of 0 behaves as 1 so the counter can never run away.
	assign wrap    = ({1'b0, vcnt_reg} + 10'h001) >= {1'b0, cur_cfg.period};

	// Counter restarts per line and per period; repeats run back to back.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			vcnt_reg      <= VPG_CNT_RST;
			reps_left_reg <= VPG_REP_RST;
		end else if (line_start) begin
			vcnt_reg      <= VPG_CNT_RST;                              // [RL16] [RL15]
			reps_left_reg <= rep_next;                                 // [RL10]
		end else if (active) begin
			if (wrap) begin
				vcnt_reg      <= VPG_CNT_RST;                          // [RL1]
				reps_left_reg <= reps_left_reg - 3'h1;                 // [RL10]
			end else begin
				vcnt_reg <= vcnt_reg + 9'h001;                         // [RL15]
			end
		end
	end

	// ----------------------------------------------------------------------
	// Phase outputs
	// ----------------------------------------------------------------------
	// Each period begins from the start level; with no repeats left the level
	// reached last simply holds, which also covers a count of 0.
	for (genvar g = 0; g < VPG_NUM_PHASE; g++) begin : g_phase
		always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
			if (!i_arst_n) begin
				phase_reg[g] <= 1'b0;
			end else if (line_start) begin
				phase_reg[g] <= i_pat_cfg[pat_next].start_level[g];    // [RL2] [RL13]
			end else if (active) begin
				phase_reg[g] <= ((vcnt_reg == VPG_CNT_RST) ? cur_cfg.start_level[g]
				                                           : phase_reg[g])
				              ^ (vcnt_reg == cur_cfg.edge_first[g])   // [RL3]
				              ^ (vcnt_reg == cur_cfg.edge_second[g]); // [RL4]
			end
		end
	end

	// Outputs are taken from registers; only the activity flag is a compare.
	assign o_vphase   = phase_reg;
	assign o_line_num = line_reg;
	assign o_region   = region_reg;
	assign o_pattern  = pat_reg;
	assign o_active   = active;

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	// Checks run on the pixel clock and are off while reset is held. Those that
	// look back one cycle read the live configuration, so software must not
	// rewrite a pattern in the very cycle a line starts.

	sequence s_line_begin;
		line_start ##1 !line_start;
	endsequence

	property p_start_level;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		line_start |=> (o_vphase == i_pat_cfg[pat_reg].start_level);
	endproperty
	a_start_level: assert property (p_start_level) else $error("phase not at start level"); // [RL2]

	property p_hold_idle;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(!active && !line_start) |=> $stable(o_vphase);
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("phase moved with no repeats"); // [RL13]

	property p_edge_first;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(active && !line_start && vcnt_reg != VPG_CNT_RST
		 && vcnt_reg == cur_cfg.edge_first[2] && vcnt_reg != cur_cfg.edge_second[2])
		|=> (o_vphase[2] != $past(o_vphase[2]));
	endproperty
	a_edge_first: assert property (p_edge_first) else $error("first edge missed"); // [RL3]

	property p_edge_second;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(active && !line_start && vcnt_reg != VPG_CNT_RST
		 && vcnt_reg == cur_cfg.edge_second[1] && vcnt_reg != cur_cfg.edge_first[1])
		|=> (o_vphase[1] != $past(o_vphase[1]));
	endproperty
	a_edge_second: assert property (p_edge_second) else $error("second edge missed"); // [RL4]

	property p_restart;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		s_line_begin |-> (vcnt_reg == VPG_CNT_RST) && (reps_left_reg == $past(rep_next));
	endproperty
	a_restart: assert property (p_restart) else $error("counter not restarted"); // [RL16]

	property p_alt01;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(line_start && ptr_next == VPG_PTR_ALT01) |=> (slot_reg == {1'b0, line_reg[0]});
	endproperty
	a_alt01: assert property (p_alt01) else $error("pointer 4 slot wrong"); // [RL6]

	property p_alt23;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(line_start && ptr_next == VPG_PTR_ALT23) |=> (slot_reg == {1'b1, line_reg[0]});
	endproperty
	a_alt23: assert property (p_alt23) else $error("pointer 5 slot wrong"); // [RL7]

	property p_direct;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(line_start && ptr_next < VPG_PTR_ALT01)
		|=> (slot_reg == $past(ptr_next[VPG_SEL_W-1:0]))
		    && (pat_reg == $past(mode.pattern_choice[ptr_next[VPG_SEL_W-1:0]]));
	endproperty
	a_direct: assert property (p_direct) else $error("direct slot wrong"); // [RL5]

	property p_field_zero;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(line_start && (field_start || field_pend_reg)) |=> (o_line_num == VPG_LINE_RST)
		&& (o_region == vpg_region(VPG_LINE_RST, $past(mode.boundary_line)));
	endproperty
	a_field_zero: assert property (p_field_zero) else $error("field did not start at line 0"); // [RL14]

	property p_last_rep;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(active && wrap && !line_start && reps_left_reg == 3'h1) |=> !o_active;
	endproperty
	a_last_rep: assert property (p_last_rep) else $error("repeat count overrun"); // [RL10]

	property p_mode_set;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(line_start && i_mode_b_sel) |=> (region_reg ==
		    vpg_region($past(line_next), $past(i_mode_b.boundary_line)));
	endproperty
	a_mode_set: assert property (p_mode_set) else $error("set B not applied"); // [RL12]

	// Lines inside a field count up by one and stop at the last line number.
	property p_line_step;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(line_start && !field_start && !field_pend_reg && line_reg != VPG_LINE_MAX)
		|=> (o_line_num == $past(line_reg) + 8'h01);
	endproperty
	a_line_step: assert property (p_line_step) else $error("line did not advance"); // [RL11]

	// Inside a period the counter steps by one pixel clock per cycle.
	property p_count_step;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(active && !line_start && !wrap) |=> (vcnt_reg == $past(vcnt_reg) + 9'h001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("counter skipped"); // [RL15]

	// A finished period restarts the counter and uses up one repetition.
	sequence s_period_end;
		active && wrap && !line_start;
	endsequence

	property p_period_end;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		s_period_end |=> (vcnt_reg == VPG_CNT_RST)
		    && (reps_left_reg == $past(reps_left_reg) - 3'h1);
	endproperty
	a_period_end: assert property (p_period_end) else $error("bad period end"); // [RL1]

	// Each period opens from the start level wherever no edge sits at position 0.
	property p_period_open;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(active && !line_start && vcnt_reg == VPG_CNT_RST
		 && cur_cfg.edge_first[3] != VPG_CNT_RST && cur_cfg.edge_second[3] != VPG_CNT_RST)
		|=> (o_vphase[3] == $past(cur_cfg.start_level[3]));
	endproperty
	a_period_open: assert property (p_period_open) else $error("bad period start"); // [RL2]

	// A count of zero leaves the line with no periods at all.
	property p_zero_reps;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(line_start && rep_next == VPG_REP_RST) |=> !o_active;
	endproperty
	a_zero_reps: assert property (p_zero_reps) else $error("count 0 still active"); // [RL13]

	// Once the repetitions are spent nothing restarts them before the next line.
	property p_spent;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(!active && !line_start) |=> !o_active && (vcnt_reg == $past(vcnt_reg));
	endproperty
	a_spent: assert property (p_spent) else $error("repeats restarted mid-line"); // [RL16]

	// The pattern of the line is the one named by the chosen slot.
	property p_pattern_pick;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		line_start |=> (o_pattern == $past(mode.pattern_choice[slot_next]));
	endproperty
	a_pattern_pick: assert property (p_pattern_pick) else $error("wrong pattern"); // [RL9]

	// The region follows from the line number and the boundaries of the set in use.
	property p_region;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		line_start |=> (o_region == vpg_region(o_line_num, $past(mode.boundary_line)));
	endproperty
	a_region: assert property (p_region) else $error("region does not match line"); // [RL11]

	// The line opens with the repeat count of the pattern it has chosen.
	property p_rep_load;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		line_start |=> (reps_left_reg == $past(mode.repeat_count[pat_next]));
	endproperty
	a_rep_load: assert property (p_rep_load) else $error("repeat count not loaded"); // [RL10]

	// With set A in use its boundaries, not those of set B, place the line.
	property p_mode_a;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		(line_start && !i_mode_b_sel) |=> (region_reg ==
		    vpg_region($past(line_next), $past(i_mode_a.boundary_line)));
	endproperty
	a_mode_a: assert property (p_mode_a) else $error("set A not applied"); // [RL12]

	// A field start seen between lines is kept until the next line start.
	sequence s_field_alone;
		field_start && !line_start;
	endsequence

	property p_field_pend;
		@(posedge i_clk_sys) disable iff (!i_arst_n)
		s_field_alone |=> field_pend_reg;
	endproperty
	a_field_pend: assert property (p_field_pend) else $error("field start lost"); // [RL14]

endmodule

`default_nettype wire

// ---- sim/vpg_ccd_model.sv ----
// Behavioural model of the sensor's vertical gates, counting phase transitions.
`timescale 1ns/1ps
`default_nettype none

module vpg_ccd_model
	import vpg_pkg::*;
(
	// Clock and reset.
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_arst_n,
	// Phase drive from the generator.
	input  wire logic [VPG_NUM_PHASE-1:0] i_vphase,
	// Running count of transitions over all four gates.
	output logic [15:0]                   o_toggles
);

	logic [VPG_NUM_PHASE-1:0] seen_reg;

	// The gates see each level one edge late, so a change is counted one cycle after it lands.
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			seen_reg  <= '0;
			o_toggles <= '0;
		end else begin
			seen_reg  <= i_vphase;
			o_toggles <= o_toggles + 16'($countones(seen_reg ^ i_vphase));
		end
	end

endmodule

`default_nettype wire

// ---- sim/vpg_core_bench.sv ----
// Self-checking bench for the vertical pattern generator.
`timescale 1ns/1ps
`default_nettype none

module vpg_core_bench;
	import vpg_pkg::*;

	// ------------------------------------------------------------------
	// Stimulus, outputs and counters
	// ------------------------------------------------------------------
	logic                           clk        = 1'b0;
	logic                           arst_n     = 1'b0;
	logic                           line_sync  = 1'b1;
	logic                           field_sync = 1'b1;
	logic                           mode_b_sel = 1'b0;
	vpg_pat_cfg_t [VPG_NUM_PAT-1:0] pat_cfg;
	vpg_mode_cfg_t                  mode_a;
	vpg_mode_cfg_t                  mode_b;
	logic [VPG_NUM_PHASE-1:0]       vphase;
	logic [VPG_LINE_W-1:0]          line_num;
	logic [VPG_REGION_W-1:0]        region;
	logic [VPG_SEL_W-1:0]           pattern;
	logic                           active;
	logic [15:0]                    toggles;
	int                             errors     = 0;
	int                             tests_run  = 0;
	int                             cycles     = 0;
	logic [VPG_REP_W-1:0]           reps [4]   = '{3'h2, 3'h1, 3'h0, 3'h3};

	// Pixel clock at 50 MHz.
	always #10 clk = ~clk;

	vpg_core i_vpg_core (
		.i_clk_sys    (clk),
		.i_arst_n     (arst_n),
		.i_line_sync  (line_sync),
		.i_field_sync (field_sync),
		.i_pat_cfg    (pat_cfg),
		.i_mode_a     (mode_a),
		.i_mode_b     (mode_b),
		.i_mode_b_sel (mode_b_sel),
		.o_vphase     (vphase),
		.o_line_num   (line_num),
		.o_region     (region),
		.o_pattern    (pattern),
		.o_active     (active)
	);

	vpg_ccd_model i_vpg_ccd_model (
		.i_clk_sys (clk),
		.i_arst_n  (arst_n),
		.i_vphase  (vphase),
		.o_toggles (toggles)
	);

	// ------------------------------------------------------------------
	// Shared helpers
	// ------------------------------------------------------------------
	task automatic report_and_stop;
		$display("Checks run %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Level after edge m of a line; the level reached at the last period end is held.
	function automatic logic [3:0] exp_ph(input int p, input int m);
		int         per;
		int         j;
		logic [3:0] v;
		per = (pat_cfg[p].period == 0) ? 1 : int'(pat_cfg[p].period);
		v = pat_cfg[p].start_level;
		if (reps[p] == 0 || m < 2) return v;
		j = m - 2;
		if (j >= reps[p] * per) j = reps[p] * per - 1;
		for (int g = 0; g < 4; g++) begin
			v[g] = v[g] ^ (pat_cfg[p].edge_first[g] <= j % per) ^ (pat_cfg[p].edge_second[g] <= j % per);
		end
		return v;
	endfunction

	// Drops the sync for one sample and returns at the falling edge after the first update.
	task automatic run_line(input logic field);
		@(negedge clk);
		line_sync = 1'b0;
		field_sync = ~field;
		@(negedge clk);
		line_sync = 1'b1;
		field_sync = 1'b1;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_pattern(input int p);
		logic [15:0] t0;
		t0 = '0;
		mode_a.pattern_choice[0] = 2'(p);
		run_line(1'b1);
		check("line", line_num, 0);
		check("pattern", pattern, p);
		check("active", active, reps[p] != 0);
		for (int m = 1; m <= 41; m++) begin
			if (m > 1) @(negedge clk);
			if (m == 2) t0 = toggles;
			check("vphase", vphase, exp_ph(p, m));
		end
		check("toggles", toggles - t0, 8 * reps[p]);
		check("active", active, 0);
	endtask

	task automatic t_regions;
		logic [2:0] slot;
		int         rg;
		mode_a.boundary_line = {8'h08, 8'h06, 8'h04, 8'h02};
		mode_a.slot_pointer = {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
		mode_a.pattern_choice = {2'h0, 2'h1, 2'h2, 2'h3};
		for (int n = 0; n < 14; n++) begin
			if (n == 12) mode_a.slot_pointer[4] = VPG_PTR_ALT23;
			run_line(n == 0);
			rg = (n >= 2) + (n >= 4) + (n >= 6) + (n >= 8);
			slot = (rg < 4) ? 3'(rg) : {1'b0, n >= 12, n[0]};
			check("line", line_num, n);
			check("region", region, rg);
			check("pattern", pattern, 3 - slot);
		end
	endtask

	// Set B places line 0 in the last region and names another pattern.
	task automatic t_mode_b;
		mode_b = mode_a;
		mode_b.boundary_line = '0;
		mode_b.slot_pointer = '0;
		mode_b.pattern_choice = 8'h55;
		mode_b_sel = 1'b1;
		run_line(1'b1);
		check("region", region, 4);
		check("pattern", pattern, 1);
		mode_b_sel = 1'b0;
		run_line(1'b1);
		check("region", region, 0);
		check("pattern", pattern, 3);
	endtask

	// A field start on its own makes the following line line 0.
	task automatic t_field_pend;
		run_line(1'b0);
		check("line", line_num, 1);
		@(negedge clk);
		field_sync = 1'b0;
		@(negedge clk);
		field_sync = 1'b1;
		run_line(1'b0);
		check("line", line_num, 0);
		check("pattern", pattern, 3);
	endtask

	// A hang is cut short well above the few hundred cycles the run needs.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			report_and_stop;
		end
	end

	initial begin
		for (int p = 0; p < 4; p++) begin
			pat_cfg[p].period = 9'(5 + p);
			pat_cfg[p].start_level = 4'(5 ^ p);
			for (int g = 0; g < 4; g++) begin
				pat_cfg[p].edge_first[g] = 9'(g);
				pat_cfg[p].edge_second[g] = 9'(g + 1 + p);
			end
		end
		mode_a = '0;
		mode_a.boundary_line = '1;
		mode_a.repeat_count = {reps[3], reps[2], reps[1], reps[0]};
		mode_b = '0;
		repeat (20) @(negedge clk);
		check("reset", vphase, 0);
		arst_n = 1'b1;
		@(negedge clk);
		for (int p = 0; p < 4; p++) t_pattern(p);
		t_regions;
		t_mode_b;
		t_field_pend;
		report_and_stop;
	end

endmodule

`default_nettype wire
